// file: rtl/bcc_cfg.svh
// Summary of operation
// - 4-bit checksum over 12-bit message
// - generator polynomial x^4 + x + 1
// - message is leading 12 bits, MSB first
// - remainder of mod-2 division, quotient dropped
// - sender writes complemented remainder as trailer
// - readback checker complements trailer before dividing
// - word valid only with zero remainder
// - combinational XOR network equals serial division
// - bad write never executes; balancers off
// - readback failure leaves device state unchanged
`ifndef BCC_CFG_SVH
`define BCC_CFG_SVH
`define BCC_CRC_W 4
`define BCC_MSG_W 12
`define BCC_WORD_W 16
`define BCC_POLY 4'h3
`define BCC_ZERO_CRC 4'h0
`define BCC_ZERO_MSG 12'h000
`endif

// file: rtl/bcc_pkg.sv
`include "bcc_cfg.svh"
package bcc_pkg;
  typedef logic [`BCC_MSG_W-1:0] bcc_msg_t;
  typedef logic [`BCC_CRC_W-1:0] bcc_crc_t;
  typedef logic [`BCC_WORD_W-1:0] bcc_word_t;

  // mod-2 long division of msg appended with four zeros; loop unrolls to xor network
  function automatic bcc_crc_t bcc_crc_f(input bcc_msg_t msg);
    bcc_crc_t r;
    logic fb;
    r = `BCC_ZERO_CRC;
    for (int i = `BCC_MSG_W - 1; i >= 0; i--)
    begin
      fb = r[`BCC_CRC_W-1] ^ msg[i];
      r = {r[`BCC_CRC_W-2:0], 1'h0} ^ (fb ? `BCC_POLY : `BCC_ZERO_CRC);
    end
    return r;
  endfunction

  // divide a whole 16-bit word; zero remainder means valid
  function automatic bcc_crc_t bcc_rem_f(input bcc_word_t w);
    return bcc_crc_f(w[`BCC_WORD_W-1:`BCC_CRC_W]) ^ w[`BCC_CRC_W-1:0];
  endfunction
endpackage

// file: rtl/bcc_link_if.sv
`timescale 1ns/1ns
interface bcc_link_if;
  logic [15:0] cmd_word;
  logic cmd_valid;
  logic exec;
  logic [15:0] rb_word;
  logic rb_valid;
  modport dev(input cmd_word, input cmd_valid, input exec, output rb_word, output rb_valid);
  modport host(output cmd_word, output cmd_valid, output exec, input rb_word, input rb_valid);
endinterface

// file: rtl/bcc_dev.sv
`timescale 1ns/1ns
`include "bcc_cfg.svh"
module bcc_dev #(
  parameter int MSG_W = `BCC_MSG_W,
  parameter int CRC_W = `BCC_CRC_W,
  parameter int WORD_W = `BCC_WORD_W
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  bcc_link_if.dev link,
  output logic [MSG_W-1:0] O_BAL_CMD,
  output logic O_CRC_ERR,
  output logic O_ACCEPTED
);

  // one division step: shift in a message bit, subtract the divisor on a leading one
  function automatic logic [CRC_W-1:0] div_step_f(
    input logic [CRC_W-1:0] r,
    input logic b
  );
    logic fb;
    fb = r[CRC_W-1] ^ b;
    return {r[CRC_W-2:0], 1'h0} ^ (fb ? `BCC_POLY : `BCC_ZERO_CRC);
  endfunction

  // fields of the incoming word
  wire [MSG_W-1:0] rx_msg;
  wire [CRC_W-1:0] rx_trl;
  // incoming trailer arrives inverted; undo it before the remainder test
  wire [CRC_W-1:0] rx_trl_fix;

  assign rx_msg = link.cmd_word[WORD_W-1:CRC_W];
  assign rx_trl = link.cmd_word[CRC_W-1:0];
  assign rx_trl_fix = ~rx_trl;

  // xor chain over the message, one stage per bit, msb first
  wire [CRC_W-1:0] rx_stage [0:MSG_W];

  assign rx_stage[0] = `BCC_ZERO_CRC;

  genvar gi;

  generate
    for (gi = 0; gi < MSG_W; gi++)
    begin : g_rx_div
      wire msg_bit;
      assign msg_bit = rx_msg[MSG_W-1-gi];
      assign rx_stage[gi+1] = div_step_f(rx_stage[gi], msg_bit);
    end
  endgenerate

  // remainder of the message alone
  wire [CRC_W-1:0] rx_crc;

  assign rx_crc = rx_stage[MSG_W];

  // remainder of the whole corrected word
  wire [CRC_W-1:0] rx_rem;
  wire rx_good;

  assign rx_rem = rx_crc ^ rx_trl_fix;
  assign rx_good = (rx_rem == `BCC_ZERO_CRC);

  // same chain over the applied command feeds the readback trailer
  wire [CRC_W-1:0] tx_stage [0:MSG_W];

  assign tx_stage[0] = `BCC_ZERO_CRC;

  generate
    for (gi = 0; gi < MSG_W; gi++)
    begin : g_tx_div
      wire cmd_bit;
      assign cmd_bit = O_BAL_CMD[MSG_W-1-gi];
      assign tx_stage[gi+1] = div_step_f(tx_stage[gi], cmd_bit);
    end
  endgenerate

  wire [CRC_W-1:0] tx_crc;
  wire [CRC_W-1:0] tx_trl;

  assign tx_crc = tx_stage[MSG_W];
  // readback trailer is sent inverted, as the host expects
  assign tx_trl = ~tx_crc;

  // strobes decoded once
  wire take_cmd;
  wire take_exec;

  assign take_cmd = link.cmd_valid;
  // an execute beside a new word is ignored: that word is not checked yet
  assign take_exec = link.exec & ~link.cmd_valid;

  // pending word, held until the next write; no retry, a refused word is dropped
  logic [MSG_W-1:0] pend_q;
  logic [MSG_W-1:0] pend_d;
  logic pend_ok_q;
  logic pend_ok_d;

  assign pend_d = take_cmd ? rx_msg : pend_q;
  assign pend_ok_d = take_cmd ? rx_good : pend_ok_q;

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_N)
    begin
      pend_q <= `BCC_ZERO_MSG;
    end
    else
    begin
      pend_q <= pend_d;
    end
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_N)
    begin
      pend_ok_q <= 1'h0;
    end
    else
    begin
      pend_ok_q <= pend_ok_d;
    end
  end

  // error flag stands until the next word arrives
  logic err_d;

  assign err_d = take_cmd ? ~rx_good : O_CRC_ERR;

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_N)
    begin
      O_CRC_ERR <= 1'h0;
    end
    else
    begin
      O_CRC_ERR <= err_d;
    end
  end

  // a failed word drives the balancers off instead of keeping a stale command
  logic [MSG_W-1:0] exec_val;
  logic [MSG_W-1:0] bal_d;
  logic acc_d;

  assign exec_val = pend_ok_q ? pend_q : `BCC_ZERO_MSG;
  assign bal_d = take_exec ? exec_val : O_BAL_CMD;
  assign acc_d = take_exec & pend_ok_q;

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_N)
    begin
      O_BAL_CMD <= `BCC_ZERO_MSG;
    end
    else
    begin
      O_BAL_CMD <= bal_d;
    end
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_N)
    begin
      O_ACCEPTED <= 1'h0;
    end
    else
    begin
      O_ACCEPTED <= acc_d;
    end
  end

  // readback mirrors the applied command; host-side failures never reach back here
  logic [WORD_W-1:0] rb_word_d;

  assign rb_word_d = {O_BAL_CMD, tx_trl};

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_N)
    begin
      link.rb_word <= 16'h0000;
    end
    else
    begin
      link.rb_word <= rb_word_d;
    end
  end

  // readback is offered every cycle once out of reset; the word trails the applied command by one cycle
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_N)
    begin
      link.rb_valid <= 1'h0;
    end
    else
    begin
      link.rb_valid <= 1'h1;
    end
  end

endmodule

// file: rtl/bcc_host.sv
`timescale 1ns/1ns
`include "bcc_cfg.svh"
module bcc_host (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  bcc_link_if.host link,
  input wire logic [11:0] i_msg,
  input wire logic i_send,
  input wire logic i_exec,
  // test hook: flips the lowest trailer bit of this write to provoke a checksum failure
  input wire logic i_corrupt,
  output logic O_RB_OK,
  output logic O_RB_ERR,
  output logic [11:0] O_RB_DATA
);
  wire [3:0] wr_crc = ~bcc_pkg::bcc_crc_f(i_msg);
  wire [3:0] wr_flip = {3'h0, i_corrupt};
  wire [15:0] rb_fixed = {link.rb_word[15:4], ~link.rb_word[3:0]};
  wire rb_good = (bcc_pkg::bcc_rem_f(rb_fixed) == `BCC_ZERO_CRC);

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_N)
    begin
      link.cmd_word <= 16'h0000;
      link.cmd_valid <= 1'b0;
      link.exec <= 1'b0;
      O_RB_OK <= 1'b0;
      O_RB_ERR <= 1'b0;
      O_RB_DATA <= `BCC_ZERO_MSG;
    end
    else
    begin
      link.cmd_valid <= i_send;
      link.exec <= i_exec & ~i_send;
      if (i_send)
        link.cmd_word <= {i_msg, wr_crc ^ wr_flip};
      // a bad readback is only flagged; nothing is sent back to the device
      O_RB_OK <= link.rb_valid & rb_good;
      O_RB_ERR <= link.rb_valid & ~rb_good;
      if (link.rb_valid & rb_good)
        O_RB_DATA <= link.rb_word[15:4];
    end
  end
endmodule

// file: verif/bcc_chk_props.sv
`timescale 1ns/1ns
package bcc_v_pkg;
  function automatic logic [3:0] crc(input logic [11:0] m);
    logic [3:0] r = 4'h0;
    for (int i = 11; i >= 0; i--) r = {r[2:0], 1'b0} ^ ((r[3] ^ m[i]) ? 4'h3 : 4'h0);
    return r;
  endfunction
endpackage
module bcc_chk (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic [15:0] cmd_word,
  input wire logic cmd_valid,
  input wire logic exec,
  input wire logic [15:0] rb_word,
  input wire logic rb_valid,
  input wire logic inj
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);
  property p_wr;
    cmd_valid && !$past(inj) |-> cmd_word[3:0] == ~bcc_v_pkg::crc(cmd_word[15:4]);
  endproperty
  a_wr: assert property (p_wr) else $error("write trailer");
  // first readback cycle skipped, though its word already holds the zero command with trailer F
  property p_rd; rb_valid && $past(rb_valid) |-> rb_word[3:0] == ~bcc_v_pkg::crc(rb_word[15:4]); endproperty
  a_rd: assert property (p_rd) else $error("readback trailer");
  property p_ex;
    (cmd_valid && cmd_word[3:0] == ~bcc_v_pkg::crc(cmd_word[15:4])) ##1 exec
      |-> ##2 rb_word[15:4] == $past(cmd_word[15:4], 3);
  endproperty
  a_ex: assert property (p_ex) else $error("command not applied");
  property p_st; !exec [*3] |=> $stable(rb_word); endproperty
  a_st: assert property (p_st) else $error("state moved");
  property p_bad;
    (cmd_valid && cmd_word[3:0] != ~bcc_v_pkg::crc(cmd_word[15:4])) ##1 exec
      |-> ##2 rb_word[15:4] == 12'h000;
  endproperty
  a_bad: assert property (p_bad) else $error("bad word executed");
  property p_ord; exec |-> !cmd_valid; endproperty
  a_ord: assert property (p_ord) else $error("execute beside word");
  c_bad: cover property (cmd_valid && cmd_word[3:0] != ~bcc_v_pkg::crc(cmd_word[15:4]));
  c_wr: cover property (cmd_valid);
  c_ex: cover property (cmd_valid ##1 exec);
  c_rd: cover property (rb_valid);
endmodule

// file: verif/balance_command_crc4_tb.sv
`timescale 1ns/1ns
module balance_command_crc4_tb;
  logic I_SYS_CLK = 0, I_RST_N = 0, send = 0, ex = 0, bad = 0, err, acc, rbok, rberr;
  logic [11:0] msg = 12'h000, bal, rbd, want;
  logic [31:0] s = 99;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  logic [11:0] q[$];
  always #25 I_SYS_CLK = ~I_SYS_CLK;
  bcc_link_if lk ();
  bcc_dev bcc_dev_inst (.I_SYS_CLK, .I_RST_N, .link(lk), .O_BAL_CMD(bal), .O_CRC_ERR(err),
    .O_ACCEPTED(acc));
  bcc_host bcc_host_inst (.I_SYS_CLK, .I_RST_N, .link(lk), .i_msg(msg), .i_send(send),
    .i_exec(ex), .i_corrupt(bad), .O_RB_OK(rbok), .O_RB_ERR(rberr), .O_RB_DATA(rbd));
  bcc_chk bcc_chk_inst (.I_SYS_CLK, .I_RST_N, .cmd_word(lk.cmd_word), .cmd_valid(lk.cmd_valid),
    .exec(lk.exec), .rb_word(lk.rb_word), .rb_valid(lk.rb_valid), .inj(bad));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task chk(input logic [11:0] a, input logic [11:0] b);
    num_checks++;
    if (a !== b)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h want %h", $time, a, b);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(negedge I_SYS_CLK)
  begin
    cyc++;
    if (acc === 1'b1) chk(bal, q.pop_front());
    if (acc === 1'b1) chk({11'h0, err}, 12'h000);
    n_mismatch += (cyc > 400);
    if (cyc > 400) report_and_stop;
  end
  initial
  begin
    repeat (6) @(posedge I_SYS_CLK);
    #2 I_RST_N = 1;
    for (int t = 0; t < 20; t++)
    begin
      @(posedge I_SYS_CLK);
      #2 s = xs(s);
      // first word is a known reference: trailer must come out 2
      msg = t ? s[11:0] : 12'hC10;
      // every fourth word goes out with a broken trailer
      bad = (t % 4 == 3);
      want = bad ? 12'h000 : msg;
      send = 1;
      if (!bad) q.push_back(msg);
      @(posedge I_SYS_CLK);
      #2 send = 0;
      bad = 0;
      ex = 1;
      @(posedge I_SYS_CLK);
      #2 ex = 0;
      repeat (6) @(posedge I_SYS_CLK);
      chk(rbd, want);
      chk(bal, want);
      chk({11'h000, err}, (t % 4 == 3) ? 12'h001 : 12'h000);
      chk({10'h000, rbok, rberr}, 12'h002);
      $display("test %0d done", t);
    end
    report_and_stop;
  end
endmodule
